// ===== eth_pkg.sv
`default_nettype none
package eth_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and loop timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SENSE_CONV_TIME_MS = 66;
	localparam int SENSE_CONV_CYCLES = SENSE_CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CONV_CNT_W = 20;
	localparam logic [1:0] CONV_LAST = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] CMD_OVER_TEMP_FAULT_LIMIT = 8'h4f;
	localparam logic [7:0] CMD_OVER_TEMP_WARN_LIMIT = 8'h51;
	localparam logic [7:0] CMD_UNDER_TEMP_WARN_LIMIT = 8'h52;
	localparam logic [7:0] CMD_UNDER_TEMP_FAULT_LIMIT = 8'h53;
	localparam logic [7:0] CMD_SENSE_HEAT_RISE = 8'hb8;
	localparam logic [7:0] CMD_HEAT_RISE_TAU_INVERSE = 8'hb9;
	localparam logic [7:0] CMD_HEAT_RISE_THERMAL_RESISTANCE = 8'hba;
	localparam logic [7:0] CMD_SENSE_GAIN_TEMP_COEFF = 8'hf6;
	localparam logic [7:0] CMD_EXT_TEMP_IDEALITY_SCALE = 8'hf8;
	localparam logic [7:0] CMD_EXT_TEMP_OFFSET_TRIM = 8'hf9;

	////////////////////////////////////////////////////////////////////////////
	// Reset values (temperatures in 0.01 degC)
	localparam logic [15:0] RST_IDEALITY_SCALE = 16'h4000;
	localparam logic [15:0] RST_OFFSET_TRIM = 16'h0000;
	localparam logic [15:0] RST_OVER_TEMP_FAULT = 16'h1964;
	localparam logic [15:0] RST_OVER_TEMP_WARN = 16'h1770;
	localparam logic [15:0] RST_UNDER_TEMP_WARN = 16'h0000;
	localparam logic [15:0] RST_UNDER_TEMP_FAULT = 16'hfe0c;
	localparam logic [15:0] RST_THETA = 16'h0000;
	localparam logic [15:0] RST_TAU_INV = 16'h0000;
	localparam logic [15:0] RST_TEMP_COEFF = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic constants
	localparam int GAIN_FRAC_BITS = 14;
	localparam int KELVIN_OFFSET_CENTI = 27315;
	localparam int HEAT_MAX_CENTI = 5000;
	localparam int REF_TEMP_CENTI = 2500;
	localparam logic signed [15:0] TAU_ONE = 16'sh4000;
	localparam int POWER_SCALE = 100;
	localparam int POWER_SHIFT = 32;
	localparam int TC_SCALE = 703687;
	localparam int TC_SHIFT = 32;
	localparam int CORR_UNITY = 16384;
	localparam int CORR_MIN = 4096;
	localparam int CORR_MAX = 65536;
	localparam int TEMP_MIN = -32768;
	localparam int TEMP_MAX = 32767;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TEMP = 2'b01,
		ST_HEAT = 2'b10,
		ST_CORR = 2'b11
	} eth_state_t;

	function automatic logic signed [63:0] sat_range(input logic signed [63:0] v,
		input logic signed [63:0] lo, input logic signed [63:0] hi);
		sat_range = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : sat_range

endpackage : eth_pkg
`default_nettype wire

// ===== eth_calc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eth_calc_if;
	logic signed [15:0] theta;
	logic signed [15:0] tau;
	logic signed [15:0] iout;
	logic signed [16:0] vdiff;
	logic signed [15:0] ts;
	logic signed [15:0] heat_prev;
	logic signed [15:0] heat_next;
	modport calc(input theta, tau, iout, vdiff, ts, heat_prev, output heat_next);
	modport user(output theta, tau, iout, vdiff, ts, heat_prev, input heat_next);
endinterface : eth_calc_if
`default_nettype wire

// ===== eth_heat_calc.sv
`timescale 1ns/1ps
`default_nettype none
module eth_heat_calc (
	eth_calc_if.calc bus
);
	logic signed [63:0] p_theta;
	logic signed [63:0] t_elem;
	logic signed [63:0] incr;
	logic signed [63:0] result;

	always_comb begin
		// Power in 2^-24 W, theta in Q8.8, scaled to 0.01 degC
		p_theta = (64'(bus.iout) * 64'(bus.vdiff) * 64'(bus.theta)
			* 64'(eth_pkg::POWER_SCALE)) >>> eth_pkg::POWER_SHIFT;
		t_elem = 64'(bus.heat_prev) + 64'(bus.ts);
		incr = ((p_theta - t_elem) * 64'(bus.tau)) >>> eth_pkg::GAIN_FRAC_BITS;
		if (bus.theta <= 16'sh0000 || bus.tau <= 16'sh0000) begin
			result = 64'sh0;
		end else if (bus.tau >= eth_pkg::TAU_ONE) begin
			result = p_theta;
		end else begin
			result = 64'(bus.heat_prev) + incr;
		end
		// Model limited to 0..50 degC
		bus.heat_next = 16'(eth_pkg::sat_range(result, 64'sh0,
			64'(eth_pkg::HEAT_MAX_CENTI)));
	end

endmodule : eth_heat_calc
`default_nettype wire

// ===== eth_ext_temp_top.sv
// Functional notes
// - Temperature fault and warning limits are compared with the channel's external reading.
// - Reading = diode kelvin times ideality scale, minus 273.15, plus offset trim.
// - With no valid diode result the die temperature is used and scale/trim have no effect.
// - The ideality scale is unsigned 16 bit weighted by 2^-14, 0x4000 being unity.
// - Increment = (power times thermal resistance minus element temperature) times tau inverse.
// - The model updates once per temperature loop of four sense conversions.
// - The heat rise starts at zero and each update with resistance and tau inverse above zero and tau inverse below one adds the signed increment.
// - The heat rise is clamped to 0..50 degC.
// - A thermal resistance or tau inverse of zero or below forces the heat rise to zero.
// - Tau inverse of one or more sets heat rise to resistance times current times sense voltage.
// - With no valid diode result the die temperature is the model's sensor temperature.
// - The heat rise feeds the temperature correction of the sense resistance.
// - Correction = 1 + coeff * 1e-6 * (reading + heat rise - 25), clamped to 0.25..4.0.
// - The heat rise is readable by the host and cannot be written.
`timescale 1ns/1ps
`default_nettype none
module eth_ext_temp_top #(
	parameter int unsigned CONV_CYCLES = eth_pkg::SENSE_CONV_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	input wire logic cmd_write_in,
	input wire logic cmd_read_in,
	output logic [15:0] cmd_rdata_out,
	output logic cmd_rvalid_out,
	output logic cmd_nack_out,
	input wire logic [15:0] diode_kelvin_in,
	input wire logic diode_valid_in,
	input wire logic [15:0] die_temp_in,
	input wire logic [15:0] iout_in,
	input wire logic [15:0] sense_plus_voltage_in,
	input wire logic [15:0] sense_minus_voltage_in,
	output logic [15:0] ext_temp_out,
	output logic [17:0] sense_correction_out,
	output logic over_temp_fault_out,
	output logic over_temp_warn_out,
	output logic under_temp_warn_out,
	output logic under_temp_fault_out,
	output logic update_done_out
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0] ideality_scale_reg;
	logic signed [15:0] offset_trim_reg;
	logic signed [15:0] theta_reg;
	logic signed [15:0] tau_reg;
	logic signed [15:0] temp_coeff_reg;
	logic signed [15:0] ot_fault_reg;
	logic signed [15:0] ot_warn_reg;
	logic signed [15:0] ut_warn_reg;
	logic signed [15:0] ut_fault_reg;
	logic signed [15:0] heat_reg;
	logic signed [15:0] ext_temp_reg;
	logic [17:0] corr_reg;
	logic [eth_pkg::CONV_CNT_W-1:0] cycle_cnt_reg;
	logic [1:0] conv_cnt_reg;
	logic conv_pulse;
	logic loop_pulse;
	eth_pkg::eth_state_t state_reg;
	eth_pkg::eth_state_t state_next;
	logic [15:0] kelvin_cap_reg;
	logic valid_cap_reg;
	logic signed [15:0] die_cap_reg;
	logic signed [15:0] iout_cap_reg;
	logic signed [16:0] vdiff_cap_reg;
	logic signed [63:0] ext_calc;
	logic signed [15:0] ext_temp_next;
	logic signed [63:0] corr_calc;
	logic [17:0] corr_next;
	logic [15:0] rdata_next;

	function automatic logic code_known(input logic [7:0] code);
		case (code)
			eth_pkg::CMD_OVER_TEMP_FAULT_LIMIT, eth_pkg::CMD_OVER_TEMP_WARN_LIMIT,
			eth_pkg::CMD_UNDER_TEMP_WARN_LIMIT, eth_pkg::CMD_UNDER_TEMP_FAULT_LIMIT,
			eth_pkg::CMD_SENSE_HEAT_RISE, eth_pkg::CMD_HEAT_RISE_TAU_INVERSE,
			eth_pkg::CMD_HEAT_RISE_THERMAL_RESISTANCE, eth_pkg::CMD_SENSE_GAIN_TEMP_COEFF,
			eth_pkg::CMD_EXT_TEMP_IDEALITY_SCALE, eth_pkg::CMD_EXT_TEMP_OFFSET_TRIM:
				code_known = 1'b1;
			default: code_known = 1'b0;
		endcase
	endfunction : code_known

	////////////////////////////////////////////////////////////////////////////
	// Conversion timing
	assign conv_pulse = (cycle_cnt_reg == eth_pkg::CONV_CNT_W'(CONV_CYCLES - 1));
	assign loop_pulse = conv_pulse && (conv_cnt_reg == eth_pkg::CONV_LAST);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cycle_cnt_reg <= '0;
		end else if (conv_pulse) begin
			cycle_cnt_reg <= '0;
		end else begin
			cycle_cnt_reg <= cycle_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			conv_cnt_reg <= 2'h0;
		end else if (conv_pulse) begin
			conv_cnt_reg <= conv_cnt_reg + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command registers
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ideality_scale_reg <= eth_pkg::RST_IDEALITY_SCALE;
			offset_trim_reg <= eth_pkg::RST_OFFSET_TRIM;
			theta_reg <= eth_pkg::RST_THETA;
			tau_reg <= eth_pkg::RST_TAU_INV;
			temp_coeff_reg <= eth_pkg::RST_TEMP_COEFF;
			ot_fault_reg <= eth_pkg::RST_OVER_TEMP_FAULT;
			ot_warn_reg <= eth_pkg::RST_OVER_TEMP_WARN;
			ut_warn_reg <= eth_pkg::RST_UNDER_TEMP_WARN;
			ut_fault_reg <= eth_pkg::RST_UNDER_TEMP_FAULT;
		end else if (cmd_write_in) begin
			// The heat rise code has no arm here, so host writes cannot land
			case (cmd_code_in)
				eth_pkg::CMD_EXT_TEMP_IDEALITY_SCALE: ideality_scale_reg <= cmd_wdata_in;
				eth_pkg::CMD_EXT_TEMP_OFFSET_TRIM: offset_trim_reg <= cmd_wdata_in;
				eth_pkg::CMD_HEAT_RISE_THERMAL_RESISTANCE: theta_reg <= cmd_wdata_in;
				eth_pkg::CMD_HEAT_RISE_TAU_INVERSE: tau_reg <= cmd_wdata_in;
				eth_pkg::CMD_SENSE_GAIN_TEMP_COEFF: temp_coeff_reg <= cmd_wdata_in;
				eth_pkg::CMD_OVER_TEMP_FAULT_LIMIT: ot_fault_reg <= cmd_wdata_in;
				eth_pkg::CMD_OVER_TEMP_WARN_LIMIT: ot_warn_reg <= cmd_wdata_in;
				eth_pkg::CMD_UNDER_TEMP_WARN_LIMIT: ut_warn_reg <= cmd_wdata_in;
				eth_pkg::CMD_UNDER_TEMP_FAULT_LIMIT: ut_fault_reg <= cmd_wdata_in;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (cmd_code_in)
			eth_pkg::CMD_EXT_TEMP_IDEALITY_SCALE: rdata_next = ideality_scale_reg;
			eth_pkg::CMD_EXT_TEMP_OFFSET_TRIM: rdata_next = offset_trim_reg;
			eth_pkg::CMD_HEAT_RISE_THERMAL_RESISTANCE: rdata_next = theta_reg;
			eth_pkg::CMD_HEAT_RISE_TAU_INVERSE: rdata_next = tau_reg;
			eth_pkg::CMD_SENSE_GAIN_TEMP_COEFF: rdata_next = temp_coeff_reg;
			eth_pkg::CMD_OVER_TEMP_FAULT_LIMIT: rdata_next = ot_fault_reg;
			eth_pkg::CMD_OVER_TEMP_WARN_LIMIT: rdata_next = ot_warn_reg;
			eth_pkg::CMD_UNDER_TEMP_WARN_LIMIT: rdata_next = ut_warn_reg;
			eth_pkg::CMD_UNDER_TEMP_FAULT_LIMIT: rdata_next = ut_fault_reg;
			eth_pkg::CMD_SENSE_HEAT_RISE: rdata_next = heat_reg;
			default: rdata_next = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_rdata_out <= 16'h0000;
			cmd_rvalid_out <= 1'b0;
			cmd_nack_out <= 1'b0;
		end else begin
			cmd_rvalid_out <= cmd_read_in;
			if (cmd_read_in) begin
				cmd_rdata_out <= rdata_next;
			end
			// Unknown codes, and writes to the read-only heat rise, are refused
			cmd_nack_out <= ((cmd_read_in || cmd_write_in) && !code_known(cmd_code_in))
				|| (cmd_write_in && cmd_code_in == eth_pkg::CMD_SENSE_HEAT_RISE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Update sequencer
	always_comb begin
		case (state_reg)
			eth_pkg::ST_IDLE: state_next = loop_pulse ? eth_pkg::ST_TEMP : eth_pkg::ST_IDLE;
			eth_pkg::ST_TEMP: state_next = eth_pkg::ST_HEAT;
			eth_pkg::ST_HEAT: state_next = eth_pkg::ST_CORR;
			eth_pkg::ST_CORR: state_next = eth_pkg::ST_IDLE;
			default: state_next = eth_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= eth_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Inputs are frozen at loop end so one update sees one coherent sample set
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			kelvin_cap_reg <= 16'h0000;
			valid_cap_reg <= 1'b0;
			die_cap_reg <= 16'sh0000;
			iout_cap_reg <= 16'sh0000;
			vdiff_cap_reg <= 17'sh00000;
		end else if (state_reg == eth_pkg::ST_IDLE && loop_pulse) begin
			kelvin_cap_reg <= diode_kelvin_in;
			valid_cap_reg <= diode_valid_in;
			die_cap_reg <= die_temp_in;
			iout_cap_reg <= iout_in;
			vdiff_cap_reg <= $signed({sense_plus_voltage_in[15], sense_plus_voltage_in})
				- $signed({sense_minus_voltage_in[15], sense_minus_voltage_in});
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// External temperature reading
	always_comb begin
		ext_calc = (($signed({48'h0, kelvin_cap_reg}) * $signed({48'h0, ideality_scale_reg}))
			>>> eth_pkg::GAIN_FRAC_BITS) - 64'(eth_pkg::KELVIN_OFFSET_CENTI)
			+ 64'(offset_trim_reg);
		if (valid_cap_reg) begin
			ext_temp_next = 16'(eth_pkg::sat_range(ext_calc, 64'(eth_pkg::TEMP_MIN),
				64'(eth_pkg::TEMP_MAX)));
		end else begin
			ext_temp_next = die_cap_reg;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ext_temp_reg <= 16'sh0000;
		end else if (state_reg == eth_pkg::ST_TEMP) begin
			ext_temp_reg <= ext_temp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Heat-rise model
	eth_calc_if calc_bus ();

	assign calc_bus.theta = theta_reg;
	assign calc_bus.tau = tau_reg;
	assign calc_bus.iout = iout_cap_reg;
	assign calc_bus.vdiff = vdiff_cap_reg;
	assign calc_bus.ts = ext_temp_reg;
	assign calc_bus.heat_prev = heat_reg;

	eth_heat_calc u_heat_calc (
		.bus(calc_bus)
	);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			heat_reg <= 16'sh0000;
		end else if (state_reg == eth_pkg::ST_HEAT) begin
			heat_reg <= calc_bus.heat_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sense correction and limits
	always_comb begin
		corr_calc = 64'(eth_pkg::CORR_UNITY) + ((64'(temp_coeff_reg)
			* (64'(ext_temp_reg) + 64'(heat_reg) - 64'(eth_pkg::REF_TEMP_CENTI))
			* 64'(eth_pkg::TC_SCALE)) >>> eth_pkg::TC_SHIFT);
		corr_next = 18'(eth_pkg::sat_range(corr_calc, 64'(eth_pkg::CORR_MIN),
			64'(eth_pkg::CORR_MAX)));
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			corr_reg <= 18'(eth_pkg::CORR_UNITY);
		end else if (state_reg == eth_pkg::ST_CORR) begin
			corr_reg <= corr_next;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			over_temp_fault_out <= 1'b0;
			over_temp_warn_out <= 1'b0;
			under_temp_warn_out <= 1'b0;
			under_temp_fault_out <= 1'b0;
		end else if (state_reg == eth_pkg::ST_CORR) begin
			over_temp_fault_out <= ext_temp_reg > ot_fault_reg;
			over_temp_warn_out <= ext_temp_reg > ot_warn_reg;
			under_temp_warn_out <= ext_temp_reg < ut_warn_reg;
			under_temp_fault_out <= ext_temp_reg < ut_fault_reg;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			update_done_out <= 1'b0;
		end else begin
			update_done_out <= (state_reg == eth_pkg::ST_CORR);
		end
	end

	assign ext_temp_out = ext_temp_reg;
	assign sense_correction_out = corr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_update_steps;
		state_reg == eth_pkg::ST_TEMP ##1 state_reg == eth_pkg::ST_HEAT
			##1 state_reg == eth_pkg::ST_CORR ##1 state_reg == eth_pkg::ST_IDLE;
	endsequence

	chk_update_order: assert property (
		state_reg == eth_pkg::ST_IDLE && loop_pulse |=> s_update_steps)
		else $error("update steps out of order");

	chk_loop_four_conv: assert property (
		loop_pulse |=> conv_cnt_reg == 2'h0 ##0 !loop_pulse)
		else $error("loop pulse not on fourth conversion");

	chk_heat_range: assert property (
		heat_reg >= 16'sh0000 && heat_reg <= 16'sh1388)
		else $error("heat rise outside 0..50 degC");

	chk_heat_zero_cfg: assert property (
		state_reg == eth_pkg::ST_HEAT && (theta_reg <= 16'sh0000 || tau_reg <= 16'sh0000)
		|=> heat_reg == 16'sh0000)
		else $error("heat rise not forced to zero");

	chk_heat_hold: assert property (
		state_reg != eth_pkg::ST_HEAT |=> $stable(heat_reg))
		else $error("heat rise changed outside update");

	chk_heat_readonly: assert property (
		cmd_write_in && cmd_code_in == eth_pkg::CMD_SENSE_HEAT_RISE
		&& state_reg != eth_pkg::ST_HEAT |=> $stable(heat_reg) && cmd_nack_out)
		else $error("heat rise written by host");

	chk_die_fallback: assert property (
		state_reg == eth_pkg::ST_TEMP && !valid_cap_reg |=> ext_temp_reg == $past(die_cap_reg))
		else $error("die temperature not substituted");

	chk_unity_scale: assert property (
		// Above this kelvin code the reading saturates, so plain subtraction no longer holds
		state_reg == eth_pkg::ST_TEMP && valid_cap_reg && ideality_scale_reg == 16'h4000
		&& offset_trim_reg == 16'sh0000 && kelvin_cap_reg <= 16'heab2
		|=> ext_temp_reg == 16'($past(kelvin_cap_reg) - 16'h6ab3))
		else $error("unity scale reading wrong");

	chk_corr_range: assert property (
		corr_reg >= 18'h01000 && corr_reg <= 18'h10000)
		else $error("correction factor out of range");

	chk_ot_fault_flag: assert property (
		state_reg == eth_pkg::ST_CORR
		|=> over_temp_fault_out == ($past(ext_temp_reg) > $past(ot_fault_reg)))
		else $error("over-temperature fault flag wrong");

endmodule : eth_ext_temp_top
`default_nettype wire

// ===== eth_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module eth_sense_model (
	input wire logic clk_in,
	input wire logic valid_req_in,
	input wire logic [15:0] kelvin_req_in,
	output logic diode_valid_out,
	output logic [15:0] diode_kelvin_out
);
	// A failed diode network gives no stable code, so the line wanders every cycle
	logic [15:0] junk_reg = 16'ha5c3;
	always @(negedge clk_in) begin
		junk_reg <= ~junk_reg + 16'h0011;
	end
	assign diode_valid_out = valid_req_in;
	assign diode_kelvin_out = valid_req_in ? kelvin_req_in : junk_reg;
endmodule : eth_sense_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int CONV = 64;
	localparam logic [7:0] C_SCALE = eth_pkg::CMD_EXT_TEMP_IDEALITY_SCALE;
	localparam logic [7:0] C_OFF = eth_pkg::CMD_EXT_TEMP_OFFSET_TRIM;
	localparam logic [7:0] C_THETA = eth_pkg::CMD_HEAT_RISE_THERMAL_RESISTANCE;
	localparam logic [7:0] C_TAU = eth_pkg::CMD_HEAT_RISE_TAU_INVERSE;
	localparam logic [7:0] C_COEFF = eth_pkg::CMD_SENSE_GAIN_TEMP_COEFF;
	localparam logic [7:0] C_HEAT = eth_pkg::CMD_SENSE_HEAT_RISE;
	localparam logic [7:0] CODES [10] = '{eth_pkg::CMD_OVER_TEMP_FAULT_LIMIT,
		eth_pkg::CMD_OVER_TEMP_WARN_LIMIT, eth_pkg::CMD_UNDER_TEMP_WARN_LIMIT,
		eth_pkg::CMD_UNDER_TEMP_FAULT_LIMIT, C_HEAT, C_TAU, C_THETA, C_COEFF, C_SCALE, C_OFF};
	localparam logic [15:0] RSTS [10] = '{eth_pkg::RST_OVER_TEMP_FAULT,
		eth_pkg::RST_OVER_TEMP_WARN, eth_pkg::RST_UNDER_TEMP_WARN, eth_pkg::RST_UNDER_TEMP_FAULT,
		16'h0000, eth_pkg::RST_TAU_INV, eth_pkg::RST_THETA, eth_pkg::RST_TEMP_COEFF,
		eth_pkg::RST_IDEALITY_SCALE, eth_pkg::RST_OFFSET_TRIM};
	localparam logic [15:0] TAUS [4] = '{16'h0000, 16'h0350, 16'h4000, 16'hc000};
	logic clk_sys_in, rst_in, cmd_write, cmd_read, cmd_rvalid, cmd_nack, done;
	logic ot_f, ot_w, ut_w, ut_f, st_valid, dio_valid;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, st_kel, dio_kel, die, iout, vp, vm, ext_temp;
	logic [17:0] corr;
	logic [15:0] shadow [256];
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	bit seen = 1'b0;
	longint exp_heat = 0;

	eth_ext_temp_top #(.CONV_CYCLES(CONV)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata), .cmd_write_in(cmd_write),
		.cmd_read_in(cmd_read), .cmd_rdata_out(cmd_rdata), .cmd_rvalid_out(cmd_rvalid),
		.cmd_nack_out(cmd_nack), .diode_kelvin_in(dio_kel), .diode_valid_in(dio_valid),
		.die_temp_in(die), .iout_in(iout), .sense_plus_voltage_in(vp),
		.sense_minus_voltage_in(vm), .ext_temp_out(ext_temp), .sense_correction_out(corr),
		.over_temp_fault_out(ot_f), .over_temp_warn_out(ot_w), .under_temp_warn_out(ut_w),
		.under_temp_fault_out(ut_f), .update_done_out(done));
	eth_sense_model i_sense (.clk_in(clk_sys_in), .valid_req_in(st_valid),
		.kelvin_req_in(st_kel), .diode_valid_out(dio_valid), .diode_kelvin_out(dio_kel));

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask : check

	// Strobe is one cycle wide; answers are collected over the next three cycles
	task automatic access(input logic w, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] rd, output logic nk);
		@(negedge clk_sys_in);
		cmd_code = code;
		cmd_wdata = wd;
		cmd_write = w;
		cmd_read = ~w;
		@(negedge clk_sys_in);
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		rd = 16'hxxxx;
		nk = 1'b0;
		repeat (3) begin
			if (cmd_nack === 1'b1) nk = 1'b1;
			if (cmd_rvalid === 1'b1) rd = cmd_rdata;
			@(negedge clk_sys_in);
		end
	endtask : access

	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		logic [15:0] rd;
		logic nk;
		access(1'b1, code, d, rd, nk);
		shadow[code] = d;
	endtask : wr

	task automatic wait_done();
		int k;
		k = 0;
		while (done !== 1'b1 && k < 4 * CONV + 20) begin
			@(negedge clk_sys_in);
			k++;
		end
		check("update_done", 32'h1, {31'h0, done});
		@(negedge clk_sys_in);
	endtask : wait_done

	// Settings are written right after a loop so none straddles a sampling edge
	task automatic scen(input logic v, input logic [15:0] kel, dt, io, pv, mv, sc, off, th, ta,
		co);
		logic [15:0] rd;
		logic nk;
		wr(C_SCALE, sc);
		wr(C_OFF, off);
		wr(C_THETA, th);
		wr(C_TAU, ta);
		wr(C_COEFF, co);
		st_valid = v;
		st_kel = kel;
		die = dt;
		iout = io;
		vp = pv;
		vm = mv;
		wait_done();
		access(1'b0, C_HEAT, 16'h0000, rd, nk);
		check("heat_rise", exp_heat[15:0], rd);
	endtask : scen

	////////////////////////////////////////////////////////////////////////////
	function automatic longint sx(input logic [15:0] v);
		return longint'($signed(v));
	endfunction : sx

	function automatic longint clampl(input longint v, lo, hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction : clampl

	function automatic longint exp_temp();
		if (st_valid !== 1'b1) return sx(die);
		return clampl(((longint'(st_kel) * longint'(shadow[C_SCALE])) >>> 14)
			- eth_pkg::KELVIN_OFFSET_CENTI + sx(shadow[C_OFF]), -32768, 32767);
	endfunction : exp_temp

	function automatic longint heat_step(input longint h, input longint ts);
		longint th, ta, p;
		th = sx(shadow[C_THETA]);
		ta = sx(shadow[C_TAU]);
		p = (sx(iout) * (sx(vp) - sx(vm)) * th * eth_pkg::POWER_SCALE) >>> 32;
		if (th <= 0 || ta <= 0) return 0;
		if (ta >= 16384) return clampl(p, 0, eth_pkg::HEAT_MAX_CENTI);
		return clampl(h + (((p - (h + ts)) * ta) >>> 14), 0, eth_pkg::HEAT_MAX_CENTI);
	endfunction : heat_step

	function automatic longint exp_corr(input longint t, h);
		return clampl(eth_pkg::CORR_UNITY + ((sx(shadow[C_COEFF]) * (t + h - eth_pkg::REF_TEMP_CENTI)
			* eth_pkg::TC_SCALE) >>> 32), eth_pkg::CORR_MIN, eth_pkg::CORR_MAX);
	endfunction : exp_corr

	////////////////////////////////////////////////////////////////////////////
	always @(negedge clk_sys_in) begin
		longint t;
		cyc++;
		if (done === 1'b1) begin
			if (seen) check("loop_period", 4 * CONV, cyc);
			seen = 1'b1;
			cyc = 0;
			t = exp_temp();
			exp_heat = heat_step(exp_heat, t);
			check("ext_temp", {16'h0, t[15:0]}, {16'h0, ext_temp});
			check("correction", exp_corr(t, exp_heat), {14'h0, corr});
			check("ot_fault", t > sx(shadow[CODES[0]]), ot_f);
			check("ot_warn", t > sx(shadow[CODES[1]]), ot_w);
			check("ut_warn", t < sx(shadow[CODES[2]]), ut_w);
			check("ut_fault", t < sx(shadow[CODES[3]]), ut_f);
		end
	end

	initial begin
		repeat (40 * 4 * CONV + 2000) @(posedge clk_sys_in);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		logic [15:0] rd, d;
		logic nk;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		st_valid = 1'b1;
		st_kel = 16'h7478;
		die = 16'h0000;
		iout = 16'h0000;
		vp = 16'h0000;
		vm = 16'h0000;
		rst_in = 1'b1;
		for (int i = 0; i < 256; i++) shadow[i] = 16'h0000;
		for (int i = 0; i < 10; i++) shadow[CODES[i]] = RSTS[i];
		void'($urandom(32'hf74c));
		repeat (2) @(negedge clk_sys_in);
		rst_in = 1'b0;
		for (int i = 0; i < 10; i++) begin
			access(1'b0, CODES[i], 16'h0000, rd, nk);
			check("reset_value", RSTS[i], rd);
			check("read_nack", 32'h0, nk);
		end
		access(1'b0, 8'h00, 16'h0000, rd, nk);
		check("unmapped_data", 32'h0, rd);
		check("unmapped_nack", 32'h1, nk);
		access(1'b1, C_HEAT, 16'h1234, rd, nk);
		check("heat_write_nack", 32'h1, nk);
		access(1'b0, C_HEAT, 16'h0000, rd, nk);
		check("heat_after_write", 32'h0, rd);
		wait_done();
		for (int i = 0; i < 10; i++) begin
			if (CODES[i] != C_HEAT) begin
				d = 16'($urandom);
				access(1'b1, CODES[i], d, rd, nk);
				access(1'b0, CODES[i], 16'h0000, rd, nk);
				check("readback", d, rd);
				access(1'b1, CODES[i], shadow[CODES[i]], rd, nk);
			end
		end
		wait_done();
		scen(1'b1, 16'hfffc, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000,
			16'h0000, 16'h0000, 16'h7fff);
		scen(1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h4000, 16'hd8f0,
			16'h0000, 16'h0000, 16'h7fff);
		scen(1'b0, 16'h7478, 16'h0bb8, 16'h2000, 16'h1000, 16'h0000, 16'h2000, 16'h0064,
			16'h0400, 16'h1000, 16'h0f3c);
		scen(1'b1, 16'h7478, 16'h0000, 16'h7fff, 16'h7fff, 16'h8000, 16'h4000, 16'h0000,
			16'h0100, 16'h4000, 16'h0000);
		scen(1'b1, 16'h7478, 16'h0000, 16'h7fff, 16'h7fff, 16'h8000, 16'h4000, 16'h0000,
			16'hff00, 16'h4000, 16'h0000);
		scen(1'b1, 16'h7478, 16'h0000, 16'h2000, 16'h1000, 16'h0000, 16'h4000, 16'h0000,
			16'h0400, 16'h4000, 16'h0000);
		scen(1'b1, 16'h7478, 16'h0000, 16'h2000, 16'h1000, 16'h0000, 16'h4000, 16'h0000,
			16'h0400, 16'hc000, 16'h0000);
		scen(1'b1, 16'h7478, 16'h0000, 16'h2000, 16'h1000, 16'h0000, 16'h4000, 16'h0000,
			16'h0400, 16'h3fff, 16'h0000);
		// Scale steps of a quarter on kelvin codes divisible by four keep the reading exact
		repeat (20) begin
			wr(CODES[$urandom_range(0, 3)], 16'($urandom_range(0, 8000) - 1000));
			scen($urandom_range(0, 3) != 0, 16'($urandom_range(20000, 40000)) & 16'hfffc,
				16'($urandom_range(0, 8000)), 16'($urandom), 16'($urandom), 16'($urandom),
				16'($urandom_range(3, 6)) << 12, 16'($urandom_range(0, 4000) - 2000),
				16'($urandom_range(0, 2048)), TAUS[$urandom_range(0, 3)],
				16'($urandom_range(0, 8000) - 4000));
		end
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
